//--- logic/rpc_pkg.sv
// Constants and types shared by the reset and power control block
// =====================================================================
package rpc_pkg;

  // =====================================================================
  // Address map
  localparam logic [31:0] RPC_DEV_BASE         = 32'hF000_0000;
  localparam logic [31:0] RPC_OFS_DEV_RESET    = 32'h0010_C00C;
  localparam logic [31:0] RPC_ADDR_POWER_LED   = 32'hF010_C000;
  localparam logic [31:0] RPC_OFS_PAR_DMA_RST  = 32'h0001_0300;
  localparam logic [31:0] RPC_OFS_SERIAL_PAGE  = 32'h0000_5000;
  localparam logic [31:0] RPC_OFS_NETWORK_PAGE = 32'h0000_7000;
  localparam logic [31:0] RPC_OFS_PARALLEL_PG  = 32'h0000_2000;
  localparam logic [31:0] RPC_OFS_PAGE_RESET   = 32'h0000_0000;

  // =====================================================================
  // Field positions and reset values
  localparam int          RPC_DEV_BITS      = 9;
  localparam int          RPC_PLC_BLINK_BIT = 0;
  localparam int          RPC_PLC_OFF_BIT   = 1;
  localparam int          RPC_STRAP_BIT     = 0;
  localparam logic [8:0]  RPC_DEV_RESET_VAL = 9'h000;
  localparam logic [1:0]  RPC_PLC_RESET_VAL = 2'h1;
  localparam int          RPC_IDX_NETWORK   = 1;
  localparam int          RPC_IDX_PARALLEL  = 2;
  localparam int          RPC_IDX_SERIAL    = 6;

  // =====================================================================
  // Timing
  localparam int          RPC_CLK_HZ         = 10_000_000;
  localparam int          RPC_LED_FLASH_HZ   = 2;
  localparam int          RPC_LED_HALF_CYC   = RPC_CLK_HZ / (2 * RPC_LED_FLASH_HZ);
  localparam logic [3:0]  RPC_PAGE_RST_CYC   = 4'hF;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rpc_req_t;

  typedef struct packed {
    logic graphics_reset_n;
    logic keyboard_reset_n;
    logic serial_reset_n;
    logic external_io_reset;
    logic irq_unit_reset_n;
    logic audio_reset_n;
    logic parallel_reset_n;
    logic network_reset_n;
    logic scsi_block_reset_n;
  } rpc_dev_rst_t;

  typedef struct packed {
    logic             pg_s1;
    logic             pg_s2;
    logic             rst_prev;
    logic             follower;
    logic [8:0]       dev_ctl;
    logic [1:0]       pwr_led;
    logic [2:0][3:0]  pcnt;
    logic             par_dma;
    logic [31:0]      led_cnt;
    logic             blink;
    logic [31:0]      rdata;
    logic             rvalid;
    logic [8:0]       dev_n;
    logic             bus_out;
    logic             bus_oe;
    logic             pwr_n;
    logic             led;
  } rpc_state_t;

endpackage

//--- logic/rpc_top.sv
// Reset and power control: bus reset sequencing, device resets, power and LED
module rpc_top import rpc_pkg::*; #(
  parameter int unsigned LED_HALF_CYC = RPC_LED_HALF_CYC,
  parameter logic [31:0] DEV_BASE     = RPC_DEV_BASE
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RSTN,
  // Supply and strap
  input  wire logic         SUPPLY_POWER_GOOD_IN,
  input  wire logic         EXT_BUS_BIT0,
  // Shared bus reset pin
  input  wire logic         BUS_RESET_N_IN,
  output logic              BUS_RESET_N_OUT,
  output logic              BUS_RESET_N_OE,
  // Register access port
  input  rpc_req_t          REG_REQ,
  output logic [31:0]       REG_RDATA,
  output logic              REG_RVALID,
  // Device resets and power
  output rpc_dev_rst_t      DEV_RESET_N,
  output logic              PAR_DMA_RESET,
  output logic              POWER_ON_N,
  output logic              LED_ON
);

  // =====================================================================
  // Decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
    hit = (a == target);
  endfunction

  rpc_state_t s_q;
  rpc_state_t s_d;

  logic        wr_dev;
  logic        wr_pwr_led;
  logic [2:0]  wr_page;
  logic        bus_low;
  logic [8:0]  pulse_hold;
  logic [2:0][31:0] page_ofs;

  assign page_ofs[0] = RPC_OFS_SERIAL_PAGE;
  assign page_ofs[1] = RPC_OFS_NETWORK_PAGE;
  assign page_ofs[2] = RPC_OFS_PARALLEL_PG;

  // =====================================================================
  // Next state
  always_comb begin
    s_d        = s_q;
    bus_low    = ~BUS_RESET_N_IN;
    wr_dev     = REG_REQ.wr && hit(REG_REQ.addr, DEV_BASE + RPC_OFS_DEV_RESET);
    wr_pwr_led = REG_REQ.wr && hit(REG_REQ.addr, RPC_ADDR_POWER_LED);
    pulse_hold = '0;

    s_d.pg_s1 = SUPPLY_POWER_GOOD_IN;
    s_d.pg_s2 = s_q.pg_s1;

    s_d.rst_prev = BUS_RESET_N_IN;
    if (BUS_RESET_N_IN && !s_q.rst_prev) begin
      s_d.follower = EXT_BUS_BIT0;
    end

    s_d.bus_out = s_q.follower ? 1'b0 : s_q.pg_s2;
    s_d.bus_oe  = s_q.follower ? ~s_q.pg_s2 : 1'b1;

    if (wr_dev) begin
      s_d.dev_ctl = REG_REQ.wdata[RPC_DEV_BITS-1:0];
    end

    for (int i = 0; i < 3; i++) begin
      wr_page[i] = REG_REQ.wr &&
                   hit(REG_REQ.addr, DEV_BASE + page_ofs[i] + RPC_OFS_PAGE_RESET);
      if (wr_page[i]) begin
        s_d.pcnt[i] = RPC_PAGE_RST_CYC;
      end else if (s_q.pcnt[i] != 4'h0) begin
        s_d.pcnt[i] = s_q.pcnt[i] - 4'h1;
      end
    end
    pulse_hold[RPC_IDX_SERIAL]   = (s_q.pcnt[0] != 4'h0);
    pulse_hold[RPC_IDX_NETWORK]  = (s_q.pcnt[1] != 4'h0);
    pulse_hold[RPC_IDX_PARALLEL] = (s_q.pcnt[2] != 4'h0);

    s_d.par_dma = REG_REQ.wr && hit(REG_REQ.addr, DEV_BASE + RPC_OFS_PAR_DMA_RST);

    if (bus_low) begin
      s_d.dev_ctl = RPC_DEV_RESET_VAL;
      s_d.pcnt    = '0;
      s_d.par_dma = 1'b1;
    end

    s_d.dev_n = bus_low ? '0 : (s_q.dev_ctl & ~pulse_hold);

    if (wr_pwr_led) begin
      s_d.pwr_led = REG_REQ.wdata[1:0];
    end
    s_d.pwr_n = s_q.pwr_led[RPC_PLC_OFF_BIT];

    if (s_q.led_cnt >= LED_HALF_CYC - 1) begin
      s_d.led_cnt = '0;
      s_d.blink   = ~s_q.blink;
    end else begin
      s_d.led_cnt = s_q.led_cnt + 32'h1;
    end
    s_d.led = ~s_q.pwr_led[RPC_PLC_OFF_BIT] &
              (~s_q.pwr_led[RPC_PLC_BLINK_BIT] | s_q.blink);

    // Read path: unmapped reads return zero
    s_d.rvalid = REG_REQ.rd;
    s_d.rdata  = '0;
    if (REG_REQ.rd) begin
      if (hit(REG_REQ.addr, DEV_BASE + RPC_OFS_DEV_RESET)) begin
        s_d.rdata = {23'h0, s_q.dev_ctl};
      end else if (hit(REG_REQ.addr, RPC_ADDR_POWER_LED)) begin
        s_d.rdata = {30'h0, s_q.pwr_led};
      end
    end
  end

  // =====================================================================
  // State register; power control keeps its value across bus resets
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_q          <= '0;
      s_q.rst_prev <= 1'b0;
      s_q.dev_ctl  <= RPC_DEV_RESET_VAL;
      s_q.pwr_led  <= RPC_PLC_RESET_VAL;
      s_q.bus_oe   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // Outputs, all straight from flops
  assign BUS_RESET_N_OUT = s_q.bus_out;
  assign BUS_RESET_N_OE  = s_q.bus_oe;
  assign REG_RDATA       = s_q.rdata;
  assign REG_RVALID      = s_q.rvalid;
  assign DEV_RESET_N     = rpc_dev_rst_t'(s_q.dev_n);
  assign PAR_DMA_RESET   = s_q.par_dma;
  assign POWER_ON_N      = s_q.pwr_n;
  assign LED_ON          = s_q.led;

endmodule

//--- verification/rpc_peer.sv
// Second reset-sharing device on the bus reset wire
module rpc_peer (
  // Clock and control
  input  wire logic clk,
  input  wire logic hold,
  // Open-drain enable
  output logic      oe
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) oe <= hold;
endmodule

//--- verification/rpc_properties.sv
// Port checker for the reset and power control block
module rpc_properties import rpc_pkg::*; (
  // Clock and reset
  input wire logic         CLK,
  input wire logic         RSTN,
  // Supply, strap and pin
  input wire logic         SUPPLY_POWER_GOOD_IN,
  input wire logic         EXT_BUS_BIT0,
  input wire logic         BUS_RESET_N_IN,
  input wire logic         BUS_RESET_N_OUT,
  input wire logic         BUS_RESET_N_OE,
  // Registers and outputs
  input rpc_req_t          REG_REQ,
  input wire logic [31:0]  REG_RDATA,
  input wire logic         REG_RVALID,
  input rpc_dev_rst_t      DEV_RESET_N,
  input wire logic         PAR_DMA_RESET,
  input wire logic         POWER_ON_N,
  input wire logic         LED_ON
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // =====================================================
  // Assertions
  a_read_answer: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered");
  a_power_off: assert property (REG_REQ.wr && REG_REQ.addr == RPC_ADDR_POWER_LED
    |=> ##1 POWER_ON_N == $past(REG_REQ.wdata[1], 2)) else $error("power bit wrong");
  a_led_dark: assert property (POWER_ON_N |-> !LED_ON)
    else $error("led lit while off");
  a_page_hold: assert property (REG_REQ.wr
    && REG_REQ.addr == RPC_DEV_BASE + RPC_OFS_SERIAL_PAGE
    |-> ##2 !DEV_RESET_N.serial_reset_n ##14 !DEV_RESET_N.serial_reset_n)
    else $error("page reset short");
  a_bus_clears: assert property (!BUS_RESET_N_IN |-> ##2 DEV_RESET_N == '0)
    else $error("devices not held");
  a_pin_low: assert property (!SUPPLY_POWER_GOOD_IN [*4]
    |-> BUS_RESET_N_OE && !BUS_RESET_N_OUT) else $error("pin not low");
  a_sync_release: assert property ($rose(BUS_RESET_N_OUT)
    |-> $past(SUPPLY_POWER_GOOD_IN, 3)) else $error("early release");
  a_dma_pulse: assert property (REG_REQ.wr
    && REG_REQ.addr == RPC_DEV_BASE + RPC_OFS_PAR_DMA_RST
    |=> PAR_DMA_RESET) else $error("no dma reset");
endmodule

bind rpc_top rpc_properties i_props (
  .CLK                 (CLK),
  .RSTN                (RSTN),
  .SUPPLY_POWER_GOOD_IN(SUPPLY_POWER_GOOD_IN),
  .EXT_BUS_BIT0        (EXT_BUS_BIT0),
  .BUS_RESET_N_IN      (BUS_RESET_N_IN),
  .BUS_RESET_N_OUT     (BUS_RESET_N_OUT),
  .BUS_RESET_N_OE      (BUS_RESET_N_OE),
  .REG_REQ             (REG_REQ),
  .REG_RDATA           (REG_RDATA),
  .REG_RVALID          (REG_RVALID),
  .DEV_RESET_N         (DEV_RESET_N),
  .PAR_DMA_RESET       (PAR_DMA_RESET),
  .POWER_ON_N          (POWER_ON_N),
  .LED_ON              (LED_ON)
);

//--- verification/rpc_top_test.sv
// Self-checking bench for the reset and power control block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch %0t got %h", $time, (a)); end end
module rpc_top_test import rpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 8;
  logic clk = 0, rstn = 0, pg = 1, strap = 0, hold = 0;
  logic out, oe, peer_oe, rvalid, dma, pwr_n, led;
  logic [31:0] rdata;
  rpc_req_t req = '0;
  rpc_dev_rst_t dev;
  int bad_count = 0, checks = 0, n;
  logic [31:0] pages [3] = '{RPC_OFS_SERIAL_PAGE, RPC_OFS_NETWORK_PAGE, RPC_OFS_PARALLEL_PG};
  int idx [3] = '{RPC_IDX_SERIAL, RPC_IDX_NETWORK, RPC_IDX_PARALLEL};
  wire bus_n = !((oe && !out) || peer_oe);
  always #50 clk = ~clk;
  rpc_peer i_peer (.clk(clk), .hold(hold), .oe(peer_oe));
  rpc_top #(.LED_HALF_CYC(HALF)) i_dut (.CLK(clk), .RSTN(rstn),
    .SUPPLY_POWER_GOOD_IN(pg), .EXT_BUS_BIT0(strap), .BUS_RESET_N_IN(bus_n),
    .BUS_RESET_N_OUT(out), .BUS_RESET_N_OE(oe), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .DEV_RESET_N(dev), .PAR_DMA_RESET(dma),
    .POWER_ON_N(pwr_n), .LED_ON(led));
  // =====================================================
  // Access tasks
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    // Read answer stands only for the cycle after the taking edge
    @(posedge clk) req <= '0;
    #1 `CHK({rvalid, rdata}, {1'b1, e})
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (600) @(posedge clk);
    bad_count++;
    finish_test;
  end
  // =====================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    repeat (6) @(posedge clk);
    #1 `CHK({out, pwr_n}, 2'b10)
    rd(RPC_DEV_BASE + RPC_OFS_DEV_RESET, 32'h0000_0000);
    rd(RPC_ADDR_POWER_LED, 32'h0000_0001);
    rd(RPC_DEV_BASE + RPC_OFS_PAGE_RESET, 32'h0000_0000);
    $display("reset test done");
    wr(RPC_DEV_BASE + RPC_OFS_DEV_RESET, 32'hFFFF_FFFF);
    rd(RPC_DEV_BASE + RPC_OFS_DEV_RESET, 32'h0000_01FF);
    `CHK(dev, 9'h1FF)
    foreach (pages[i]) begin
      wr(RPC_DEV_BASE + pages[i], 32'h0000_0000);
      @(posedge clk) #1 `CHK(dev[idx[i]], 1'b0)
      repeat (14) @(posedge clk);
      #1 `CHK(dev[idx[i]], 1'b0)
      @(posedge clk) #1;
      `CHK(dev[idx[i]], 1'b1)
    end
    wr(RPC_DEV_BASE + RPC_OFS_PAR_DMA_RST, 32'h0000_0000);
    #1 `CHK(dma, 1'b1)
    $display("device test done");
    wr(RPC_ADDR_POWER_LED, 32'h0000_0000);
    repeat (3) @(posedge clk);
    #1 `CHK(led, 1'b1)
    wr(RPC_ADDR_POWER_LED, 32'h0000_0001);
    n = 0;
    repeat (3) @(posedge clk);
    // Two full blink periods are lit for exactly half their cycles
    repeat (4 * HALF) begin
      @(posedge clk) #1;
      n += int'(led);
    end
    `CHK(n, 2 * HALF)
    wr(RPC_ADDR_POWER_LED, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1 `CHK({pwr_n, led}, 2'b10)
    $display("power test done");
    @(posedge clk) hold <= 1;
    strap <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK(dev, 9'h000)
    wr(RPC_DEV_BASE + RPC_OFS_DEV_RESET, 32'hFFFF_FFFF);
    rd(RPC_DEV_BASE + RPC_OFS_DEV_RESET, 32'h0000_0000);
    @(posedge clk) hold <= 0;
    repeat (5) @(posedge clk);
    #1 `CHK(oe, 1'b0)
    @(posedge clk) pg <= 0;
    repeat (5) @(posedge clk);
    #1 `CHK({oe, out}, 2'b10)
    @(posedge clk) pg <= 1;
    repeat (6) @(posedge clk);
    #1 `CHK(oe, 1'b0)
    $display("bus test done");
    finish_test;
  end
endmodule
